// ==== asrc_host.v ====
/*
 * Host-side controller for a 512K x 8 asynchronous static RAM.
 * Assumes the SRAM pins are wired directly to the pin ports, the data bus
 * resolved outside from data_pin_oe, and read data sampled synchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asrc_consts.vh"

// Functional notes
// R1 - Memory holds 524,288 bytes; host addresses them all.
// R2 - Chip select and output enable are active low; bus is three-state.
// R3 - Write happens while chip select and write strobe are both low.
// R4 - Address is a 19-bit word address, bits 0 to 18.
// R5 - Device drives data when selected, output enabled, strobe high.
// R6 - Device data pins float when deselected, disabled, or writing.
// R7 - Device drops to standby whenever chip select is high.
// R8 - Host waits at least 1 us after power-up before first access.
// R9 - Read data valid 12, 15 or 20 ns after address change.
// R10 - Old read data holds at least 3 ns after address change.
// R11 - Read data valid 12, 15 or 20 ns after chip select falls.
// R12 - Read data valid 6, 7 or 8 ns after output enable falls.
// R13 - Device powers down within 12, 15 or 20 ns of deselect.
// R14 - Write address stable 10, 12 or 13 ns before write end.
// R15 - Address valid no later than write start.
// R16 - Address may change right at write end.
// R17 - Write data driven 7, 8 or 9 ns before write end.
// R18 - Write spans later falling to earlier rising strobe edge.
// R19 - Speed grade parameter; delays in whole cycles rounded up.
// R20 - Host releases data bus before asserting output enable.
module asrc_host #(
    parameter [1:0]  SPEED_GRADE   = `ASRC_GRADE_12,
    parameter [15:0] POWERUP_CYC   =
        `ASRC_CYC(`ASRC_POWERUP_WAIT_NS)
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        clk_en,
    // User request port
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [18:0] req_addr,
    input  wire [7:0]  req_wdata,
    // User response port
    output reg         req_ready,
    output reg         rsp_valid,
    output reg  [7:0]  rsp_rdata,
    // SRAM pins
    output reg  [18:0] word_addr,
    output reg         chip_sel_n,
    output reg         out_en_n,
    output reg         wr_strobe_n,
    // SRAM data bus
    input  wire [7:0]  data_pin_i,
    output reg  [7:0]  data_pin_o,
    output reg         data_pin_oe
);

    // ************************************************************
    // Grade selection
    // ************************************************************
    // An unknown grade code falls back to the slowest set, which is
    // always safe, only slower, on a faster part.
    function integer grade_ns;
        input [1:0]   grade;
        input integer ns_12;
        input integer ns_15;
        input integer ns_20;
        begin
            case (grade)
                `ASRC_GRADE_12: grade_ns = ns_12;
                `ASRC_GRADE_15: grade_ns = ns_15;
                default:        grade_ns = ns_20;
            endcase
        end
    endfunction

    localparam integer RD_NS = grade_ns(SPEED_GRADE,
        `ASRC_ADDR_TO_VALID_12, `ASRC_ADDR_TO_VALID_15,
        `ASRC_ADDR_TO_VALID_20);
    localparam integer OE_NS = grade_ns(SPEED_GRADE,
        `ASRC_OE_TO_VALID_12, `ASRC_OE_TO_VALID_15,
        `ASRC_OE_TO_VALID_20);
    localparam integer WP_NS = grade_ns(SPEED_GRADE,
        `ASRC_WRITE_PULSE_12, `ASRC_WRITE_PULSE_15,
        `ASRC_WRITE_PULSE_20);
    localparam integer SD_NS = grade_ns(SPEED_GRADE,
        `ASRC_WDATA_SETUP_12, `ASRC_WDATA_SETUP_15,
        `ASRC_WDATA_SETUP_20);
    localparam integer HZ_NS = grade_ns(SPEED_GRADE,
        `ASRC_OFF_TO_HIZ_12, `ASRC_OFF_TO_HIZ_15,
        `ASRC_OFF_TO_HIZ_20);

    // ************************************************************
    // Grade-dependent cycle counts
    // ************************************************************
    localparam [31:0] RD_CYC_W = `ASRC_CYC(RD_NS);
    localparam [31:0] OE_CYC_W = `ASRC_CYC(OE_NS);
    localparam [31:0] WP_CYC_W = `ASRC_CYC(WP_NS);
    localparam [31:0] SD_CYC_W = `ASRC_CYC(SD_NS);
    localparam [31:0] HZ_CYC_W = `ASRC_CYC(HZ_NS);
    // Every count fits four bits even at the slowest grade.
    localparam [3:0]  RD_CYC   = RD_CYC_W[3:0];
    localparam [3:0]  OE_CYC   = OE_CYC_W[3:0];
    localparam [3:0]  WP_CYC   = WP_CYC_W[3:0];
    localparam [3:0]  SD_CYC   = SD_CYC_W[3:0];
    localparam [3:0]  HZ_CYC   = HZ_CYC_W[3:0];
    // The access must cover both the address path and the enable path.
    localparam [3:0]  ACC_CYC  = (RD_CYC > OE_CYC) ? RD_CYC : OE_CYC;
    // Address and data are set up with the strobe, so the pulse must
    // also cover the data setup time.
    localparam [3:0]  WR_CYC   = (WP_CYC > SD_CYC) ? WP_CYC : SD_CYC;

    // ************************************************************
    // States
    // ************************************************************
    localparam [2:0] ST_PWRUP = 3'h0;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_READ  = 3'h2;
    localparam [2:0] ST_WRITE = 3'h3;
    localparam [2:0] ST_TURN  = 3'h4;

    reg [2:0]  state_q;
    reg [15:0] cnt_q;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q     <= ST_PWRUP;
            cnt_q       <= POWERUP_CYC;
            req_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_rdata   <= 8'h00;
            word_addr   <= 19'h00000;
            chip_sel_n  <= 1'b1;
            out_en_n    <= 1'b1;
            wr_strobe_n <= 1'b1;
            data_pin_o  <= 8'h00;
            data_pin_oe <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            case (state_q)
                ST_PWRUP: begin
                    // Counting starts at reset release; hold reset until
                    // the supply is up so the wait is measured from there.
                    if (cnt_q <= 16'h0001) begin // R8
                        state_q   <= ST_IDLE;
                        req_ready <= 1'b1;
                    end
                    cnt_q <= cnt_q - 16'h0001;
                end
                ST_IDLE: begin
                    if (req_valid) begin
                        req_ready  <= 1'b0;
                        word_addr  <= req_addr; // R1 R4 R15
                        chip_sel_n <= 1'b0; // R2
                        if (req_write) begin
                            // Strobe falls with address: zero lead allowed.
                            wr_strobe_n <= 1'b0; // R3 R18
                            data_pin_o  <= req_wdata; // R17
                            data_pin_oe <= 1'b1;
                            cnt_q       <= {12'h000, WR_CYC}; // R14 R17 R19
                            state_q     <= ST_WRITE;
                        end else begin
                            data_pin_oe <= 1'b0; // R20
                            out_en_n    <= 1'b0; // R12
                            cnt_q       <= {12'h000, ACC_CYC}; // R9 R11
                            state_q     <= ST_READ;
                        end
                    end else begin
                        chip_sel_n <= 1'b1; // R7
                    end
                end
                ST_WRITE: begin
                    if (cnt_q <= 16'h0001) begin
                        // Write ends here; address and data change after.
                        wr_strobe_n <= 1'b1; // R16 R18
                        chip_sel_n  <= 1'b1; // R13
                        cnt_q       <= 16'h0001;
                        state_q     <= ST_TURN;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_READ: begin
                    if (cnt_q <= 16'h0001) begin
                        rsp_rdata  <= data_pin_i; // R5 R10
                        rsp_valid  <= 1'b1;
                        out_en_n   <= 1'b1;
                        chip_sel_n <= 1'b1; // R6 R13
                        // Wait out the device's float time before any
                        // host drive can follow.
                        cnt_q      <= {12'h000, HZ_CYC};
                        state_q    <= ST_TURN;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_TURN: begin
                    // After a write the host drive is dropped one cycle
                    // past the strobe; the device needs no data hold.
                    data_pin_oe <= 1'b0;
                    if (cnt_q <= 16'h0001) begin
                        req_ready <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end

endmodule // asrc_host

`default_nettype wire

// ==== asrc_consts.vh ====
/*
 * Timing and width constants for the asynchronous SRAM host controller.
 * Assumes a 200 MHz system clock (5 ns period); times in ns, clock period in ps.
 */
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define ASRC_ADDR_W        19
`define ASRC_DATA_W        8
`define ASRC_DEPTH         524288

// ****************************************************************
// Clock
// ****************************************************************
`define ASRC_CLK_PS        5000

// ****************************************************************
// Speed grade codes
// ****************************************************************
`define ASRC_GRADE_12      2'h0
`define ASRC_GRADE_15      2'h1
`define ASRC_GRADE_20      2'h2

// ****************************************************************
// Times in ns, per grade except the power-up wait
// ****************************************************************
`define ASRC_POWERUP_WAIT_NS     1000
`define ASRC_ADDR_TO_VALID_12    12
`define ASRC_ADDR_TO_VALID_15    15
`define ASRC_ADDR_TO_VALID_20    20
`define ASRC_OE_TO_VALID_12      6
`define ASRC_OE_TO_VALID_15      7
`define ASRC_OE_TO_VALID_20      8
`define ASRC_WRITE_PULSE_12      10
`define ASRC_WRITE_PULSE_15      12
`define ASRC_WRITE_PULSE_20      13
`define ASRC_WDATA_SETUP_12      7
`define ASRC_WDATA_SETUP_15      8
`define ASRC_WDATA_SETUP_20      9
`define ASRC_OFF_TO_HIZ_12       6
`define ASRC_OFF_TO_HIZ_15       7
`define ASRC_OFF_TO_HIZ_20       8

// Least time in ns to whole cycles, rounded up, at least one.
`define ASRC_CYC(ns) ((((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS) < 1 \
    ? 1 : (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS))

`endif

// ==== asrc_host_monitor.sv ====
/* Pin and user-port checker for asrc_host.
   Assumes grade 12 timing and a 5 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module asrc_host_monitor #(parameter int POWERUP_CYC = 200) (
    input wire logic        clk_sys, rst_n, clk_en, req_valid, req_write,
    input wire logic        req_ready, rsp_valid, chip_sel_n,
    input wire logic        out_en_n, wr_strobe_n, data_pin_oe,
    input wire logic [7:0]  rsp_rdata, data_pin_i, data_pin_o,
    input wire logic [18:0] word_addr
);
    logic [15:0] up_q;
    wire         take = req_valid && req_ready;
    always @(posedge clk_sys)
        up_q <= !rst_n ? 16'h0 : up_q + {15'h0, up_q != 16'hffff};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !clk_en);
    property p_up; up_q < POWERUP_CYC |-> !req_ready; endproperty
    a_up: assert property (p_up) else $error("ready too early");
    property p_rd; take && !req_write |=> !rsp_valid [*3] ##1 rsp_valid
        ##1 !rsp_valid; endproperty
    a_rd: assert property (p_rd) else $error("read latency");
    property p_rdpin; take && !req_write |=> (!chip_sel_n && !out_en_n &&
        wr_strobe_n && !data_pin_oe) [*3] ##1 (chip_sel_n && out_en_n);
    endproperty
    a_rdpin: assert property (p_rdpin) else $error("read pins");
    property p_wr; take && req_write |=> (!chip_sel_n && !wr_strobe_n &&
        data_pin_oe) [*2] ##1 (chip_sel_n && wr_strobe_n && data_pin_oe)
        ##1 !data_pin_oe; endproperty
    a_wr: assert property (p_wr) else $error("write pins");
    property p_stab; !wr_strobe_n && $past(!wr_strobe_n) |->
        $stable(word_addr) && $stable(data_pin_o); endproperty
    a_stab: assert property (p_stab) else $error("write moved");
    property p_oe; !out_en_n |-> !data_pin_oe; endproperty
    a_oe: assert property (p_oe) else $error("bus fight");
    property p_cs; chip_sel_n |-> out_en_n && wr_strobe_n; endproperty
    a_cs: assert property (p_cs) else $error("strobe unselected");
    property p_hz; $rose(out_en_n) |-> !data_pin_oe [*2]; endproperty
    a_hz: assert property (p_hz) else $error("turnaround short");
    property p_dat; rsp_valid |-> rsp_rdata == $past(data_pin_i);
    endproperty
    a_dat: assert property (p_dat) else $error("read byte");
endmodule // asrc_host_monitor
bind asrc_host asrc_host_monitor #(.POWERUP_CYC(POWERUP_CYC)) u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid),
    .req_write(req_write), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .data_pin_oe(data_pin_oe),
    .rsp_rdata(rsp_rdata), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .word_addr(word_addr));
`default_nettype wire

// ==== asrc_sram_model.sv ====
/* Behavioural 512K x 8 SRAM seen by asrc_host.
   Assumes host pins wired straight in; no pull on the data bus. */
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model #(parameter int ACC_NS = 12) (
    input  wire logic [18:0] word_addr,
    input  wire logic        chip_sel_n, out_en_n, wr_strobe_n,
    input  wire logic [7:0]  data_pin_o,
    input  wire logic        data_pin_oe,
    output wire logic [7:0]  data_pin_i
);
    logic [7:0] mem [0:524287];
    logic [7:0] last_q = 8'h00;
    wire        drv = !chip_sel_n && !out_en_n && wr_strobe_n;
    wire        drv_dly;
    wire [7:0]  rd;
    // Old data lingers for the hold time after an address change.
    assign #3 rd = mem[word_addr];
    // Data is withheld until the access time passes, so early samples fail.
    assign #(ACC_NS) drv_dly = drv;
    wire        drv_ok = drv && drv_dly;
    always @(negedge drv_ok) last_q = rd;
    always @* if (!chip_sel_n && !wr_strobe_n)
        mem[word_addr] = data_pin_oe ? data_pin_o : ~last_q;
    assign data_pin_i = data_pin_oe ? data_pin_o : drv_ok ? rd : ~last_q;
endmodule // asrc_sram_model
`default_nettype wire

// ==== tb_asrc_host.sv ====
/* Self-checking bench for asrc_host with the SRAM model.
   Assumes grade 12 timing and a shortened power-up wait. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb_asrc_host;
    logic        clk_sys = 0, rst_n = 0, req_valid = 0, req_write = 0;
    logic        clk_en = 1;
    logic [18:0] req_addr = 0, adr [32];
    logic [7:0]  req_wdata = 0, exp_mem [int];
    logic [16:0] lfsr_q = 17'h10a85;
    wire         req_ready, rsp_valid, chip_sel_n, out_en_n, wr_strobe_n;
    wire         data_pin_oe;
    wire [7:0]   rsp_rdata, data_pin_i, data_pin_o;
    wire [18:0]  word_addr;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    asrc_host #(.SPEED_GRADE(2'h0), .POWERUP_CYC(16'h4)) u_asrc_host (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .word_addr(word_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_strobe_n(wr_strobe_n), .data_pin_i(data_pin_i),
        .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));
    asrc_sram_model u_asrc_sram_model (.word_addr(word_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_strobe_n(wr_strobe_n), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .data_pin_i(data_pin_i));
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic int cyc_of(input int ns);
        return (ns * 1000 + 4999) / 5000;
    endfunction
    task automatic access(input logic wr, input logic [18:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        req_valid = 1; req_write = wr; req_addr = a; req_wdata = d;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        #1 req_valid = 0;
        if (wr) exp_mem[a] = d;
        else begin
            do begin @(posedge clk_sys); #1 n++; end
            while (rsp_valid !== 1'b1 && n < 20);
            `CHK(rsp_rdata, exp_mem[a])
            `CHK(n, cyc_of(12))
        end
    endtask
    task automatic refused(input logic [18:0] a);
        @(posedge clk_sys);
        #1;
        req_valid = 1; req_write = 1; req_addr = a; req_wdata = 8'h00;
        @(posedge clk_sys);
        #1 req_valid = 0;
        `CHK(wr_strobe_n, 1'b1)
    endtask
    task automatic powerup_check;
        repeat (4) begin
            `CHK(req_ready, 1'b0)
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic freeze(input logic [18:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 clk_en = 0;
        req_valid = 1; req_write = 1; req_addr = a; req_wdata = d;
        repeat (3) begin
            @(posedge clk_sys);
            #1;
            `CHK(wr_strobe_n, 1'b1)
        end
        clk_en = 1;
        @(posedge clk_sys);
        #1 req_valid = 0;
        exp_mem[a] = d;
        `CHK(wr_strobe_n, 1'b0)
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc > 20000) begin
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst_n = 1;
        powerup_check();
        $display("powerup test done");
        freeze(19'h00000, 8'h3c);
        $display("freeze test done");
        access(1, 19'h00000, 8'ha5);
        access(1, 19'h7ffff, 8'h5a);
        refused(19'h7ffff);
        access(0, 19'h00000, 8'h00);
        access(0, 19'h7ffff, 8'h00);
        $display("corner test done");
        for (int i = 0; i < 32; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            adr[i] = {lfsr_q[1:0], lfsr_q};
            lfsr_q = lfsr_next(lfsr_q);
            access(1, adr[i], lfsr_q[7:0]);
            access(0, adr[lfsr_q[12:8] % (i + 1)], 8'h00);
        end
        $display("random test done");
        @(posedge clk_sys);
        #1 rst_n = 0;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1;
        `CHK({chip_sel_n, out_en_n, wr_strobe_n, data_pin_oe}, 4'he)
        powerup_check();
        access(0, 19'h7ffff, 8'h00);
        $display("reset test done");
        report_and_stop();
    end
endmodule // tb_asrc_host
`default_nettype wire
